/* File: pin_sel_regs.svh */
// register offsets, field positions, reset values and pin map of the pin function selector
`ifndef PIN_SEL_REGS_SVH
`define PIN_SEL_REGS_SVH
`define OFS_PORT_DATA_LO 8'h00
`define OFS_PORT_DATA_HI 8'h04
`define OFS_PORT_DIR_LO 8'h08
`define OFS_PORT_DIR_HI 8'h0C
`define OFS_PIN_LEVEL_LO 8'h10
`define OFS_PIN_LEVEL_HI 8'h14
`define OFS_UPPER_ADDR 8'h18
`define OFS_BUS_PIN_CTRL 8'h1C
`define OFS_BUS_MODE 8'h20
`define OFS_PERIPH_SEL 8'h24
`define OFS_ANALOG_EN 8'h28
`define BPC_WR_STROBE 0
`define BPC_HOLD 1
`define BPC_READY 2
`define BPC_CKE 3
`define MODE_EXT 0
`define MODE_MUX 1
`define MODE_W16 2
`define PSEL_PPG 0
`define PSEL_TOT 4
`define PSEL_UART 7
`define RST_UPPER_ADDR 4'h0
`define RST_BUS_PIN_CTRL 4'h0
`define RST_BUS_MODE 3'h0
`define RST_PERIPH_SEL 9'h000
`define RST_ANALOG_EN 16'h0000
`define PIN_COUNT 44
`define PIN_P2U 0
`define PIN_P3 4
`define PIN_P4 12
`define PIN_P5 20
`define PIN_AN 28
`define P5_ALE 0
`define P5_RD 1
`define P5_WR_LO 2
`define P5_WR_HI 3
`define P5_HOLD_REQ 4
`define P5_HOLD_ACK 5
`define P5_RDY 6
`define P5_CLK 7
`define PIN_TIN0 12
`define PIN_TOT0 13
`define PIN_TIN1 4
`define PIN_TOT1 5
`define PIN_TIN2 6
`define PIN_TOT2 7
`define PIN_SIN0 14
`define PIN_SOT0 15
`define PIN_SCK0 16
`define PIN_SIN1 17
`define PIN_SOT1 18
`define PIN_SCK1 19
`endif

/* File: pin_sel_pkg.sv */
// types shared by the pin function selector
package pin_sel_pkg;
   typedef enum logic [1:0] {
      HTRANS_IDLE = 2'b00,
      HTRANS_BUSY = 2'b01,
      HTRANS_NONSEQ = 2'b10,
      HTRANS_SEQ = 2'b11
   } htrans_t;
   typedef struct packed {
      logic [23:0] addr;
      logic ale;
      logic rd_n;
      logic wr_lo_n;
      logic wr_hi_n;
      logic hold_ack;
      logic mclk;
   } bus_func_t;
   typedef struct packed {
      logic [3:0] ppg;
      logic [2:0] tot;
      logic [1:0] sot;
      logic [1:0] sck;
      logic [1:0] sck_oe;
   } periph_out_t;
endpackage

/* File: pin_input_sync.sv */
// two-stage synchroniser for the pin inputs
`timescale 1ns/1ps
module pin_input_sync #(
   parameter int W = 44
) (
   input wire logic core_clk, // machine clock
   input wire logic rst, // synchronous reset
   input wire logic [W-1:0] async_in, // raw pin levels
   output logic [W-1:0] sync_out // levels after two flops
);
   logic [W-1:0] stage1;
   always_ff @(posedge core_clk) begin
      if (rst) begin
         stage1 <= '0;
         sync_out <= '0;
      end else begin
         stage1 <= async_in;
         sync_out <= stage1;
      end
   end
endmodule

/* File: pin_output_cell.sv */
// one registered output path per pin, shared by port and function
`timescale 1ns/1ps
module pin_output_cell #(
   parameter int W = 44
) (
   input wire logic core_clk, // machine clock
   input wire logic rst, // synchronous reset
   input wire logic [W-1:0] port_data, // port data register
   input wire logic [W-1:0] port_dir, // port direction, 1 drives
   input wire logic [W-1:0] func_sel, // pin given to a function
   input wire logic [W-1:0] func_out, // function output level
   input wire logic [W-1:0] func_oe, // function drives pin
   output logic [W-1:0] pin_out, // pin output level
   output logic [W-1:0] pin_oe // pin output enable
);
   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_pin
         always_ff @(posedge core_clk) begin
            if (rst) begin
               pin_out[i] <= 1'b0;
               pin_oe[i] <= 1'b0;
            end else if (func_sel[i]) begin
               pin_out[i] <= func_out[i];
               pin_oe[i] <= func_oe[i];
            end else begin
               pin_out[i] <= port_data[i];
               pin_oe[i] <= port_dir[i];
            end
         end
      end
   endgenerate
endmodule

/* File: pin_function_select.sv */
// pin function selector for the shared port pins, with its AHB-Lite register slave
//
// Local design decisions: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "pin_sel_regs.svh"
module pin_function_select (
   input wire logic core_clk, // machine clock
   input wire logic rst, // synchronous reset
   input wire logic hsel, // slave select
   input wire logic [31:0] haddr, // byte address
   input wire logic [1:0] htrans, // transfer type
   input wire logic hwrite, // write transfer
   input wire logic [2:0] hsize, // transfer size, words only
   input wire logic [31:0] hwdata, // write data
   input wire logic hready, // bus ready
   output logic hreadyout, // slave ready
   output logic [31:0] hrdata, // read data
   output logic hresp, // always okay
   input wire pin_sel_pkg::bus_func_t bus_func, // external bus controller outputs
   input wire pin_sel_pkg::periph_out_t periph, // peripheral outputs
   input wire logic standby, // standby mode
   input wire logic [`PIN_COUNT-1:0] pin_in, // pin levels
   output logic [`PIN_COUNT-1:0] pin_out, // pin output levels
   output logic [`PIN_COUNT-1:0] pin_oe, // pin output enables
   output logic hold_request, // hold request to bus controller
   output logic ext_ready, // ready to bus controller
   output logic [2:0] timer_in, // reload timer event inputs
   output logic [1:0] serial_in, // uart data inputs
   output logic [15:0] analog_connect // converter input switches
);
   logic [`PIN_COUNT-1:0] port_data;
   logic [`PIN_COUNT-1:0] port_dir;
   logic [3:0] upper_address_output_ctrl;
   logic [3:0] bus_pin_control;
   logic [2:0] bus_mode;
   logic [8:0] periph_sel;
   logic [15:0] analog_input_enable_reg;
   logic [`PIN_COUNT-1:0] pin_sync;
   logic [`PIN_COUNT-1:0] pin_seen;
   logic [`PIN_COUNT-1:0] func_sel;
   logic [`PIN_COUNT-1:0] func_out;
   logic [`PIN_COUNT-1:0] func_oe;
   logic ap_write;
   logic [7:0] ap_addr;
   logic take;
   logic ext_mode;
   logic mux_mode;
   logic w16_mode;
   logic nmux_bus;

   assign ext_mode = bus_mode[`MODE_EXT];
   assign mux_mode = bus_mode[`MODE_MUX];
   assign w16_mode = bus_mode[`MODE_W16];
   assign nmux_bus = ext_mode && !mux_mode;
   assign take = hsel && hready &&
      (htrans == pin_sel_pkg::HTRANS_NONSEQ || htrans == pin_sel_pkg::HTRANS_SEQ);

   function automatic logic wr_hit(input logic [7:0] ofs);
      return ap_write && ap_addr == ofs;
   endfunction

   function automatic logic [31:0] read_word(input logic [7:0] a);
      logic [31:0] w;
      w = 32'h0000_0000;
      case (a)
         `OFS_PORT_DATA_LO: w = port_data[31:0];
         `OFS_PORT_DATA_HI: w[`PIN_COUNT-33:0] = port_data[`PIN_COUNT-1:32];
         `OFS_PORT_DIR_LO: w = port_dir[31:0];
         `OFS_PORT_DIR_HI: w[`PIN_COUNT-33:0] = port_dir[`PIN_COUNT-1:32];
         `OFS_PIN_LEVEL_LO: w = pin_seen[31:0];
         `OFS_PIN_LEVEL_HI: w[`PIN_COUNT-33:0] = pin_seen[`PIN_COUNT-1:32];
         `OFS_UPPER_ADDR: w[3:0] = upper_address_output_ctrl;
         `OFS_BUS_PIN_CTRL: w[3:0] = bus_pin_control;
         `OFS_BUS_MODE: w[2:0] = bus_mode;
         `OFS_PERIPH_SEL: w[8:0] = periph_sel;
         `OFS_ANALOG_EN: w[15:0] = analog_input_enable_reg;
         default: w = 32'h0000_0000;
      endcase
      return w;
   endfunction

   // address phase capture; zero wait states
   always_ff @(posedge core_clk) begin
      if (rst) begin
         ap_write <= 1'b0;
         ap_addr <= 8'h00;
      end else if (hready) begin
         ap_write <= take && hwrite;
         ap_addr <= haddr[7:0];
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         hrdata <= 32'h0000_0000;
      end else if (take && !hwrite) begin
         hrdata <= read_word(haddr[7:0]);
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         hreadyout <= 1'b0;
         hresp <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   // port data and direction, writable at any time
   always_ff @(posedge core_clk) begin
      if (rst) begin
         port_data <= '0;
      end else begin
         if (wr_hit(`OFS_PORT_DATA_LO)) begin
            port_data[31:0] <= hwdata;
         end
         if (wr_hit(`OFS_PORT_DATA_HI)) begin
            port_data[`PIN_COUNT-1:32] <= hwdata[`PIN_COUNT-33:0];
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         port_dir <= '0;
      end else begin
         if (wr_hit(`OFS_PORT_DIR_LO)) begin
            port_dir[31:0] <= hwdata;
         end
         if (wr_hit(`OFS_PORT_DIR_HI)) begin
            port_dir[`PIN_COUNT-1:32] <= hwdata[`PIN_COUNT-33:0];
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         upper_address_output_ctrl <= `RST_UPPER_ADDR;
         bus_pin_control <= `RST_BUS_PIN_CTRL;
         bus_mode <= `RST_BUS_MODE;
      end else begin
         if (wr_hit(`OFS_UPPER_ADDR)) begin
            upper_address_output_ctrl <= hwdata[3:0];
         end
         if (wr_hit(`OFS_BUS_PIN_CTRL)) begin
            bus_pin_control <= hwdata[3:0];
         end
         if (wr_hit(`OFS_BUS_MODE)) begin
            bus_mode <= hwdata[2:0];
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         periph_sel <= `RST_PERIPH_SEL;
         analog_input_enable_reg <= `RST_ANALOG_EN;
      end else begin
         if (wr_hit(`OFS_PERIPH_SEL)) begin
            periph_sel <= hwdata[8:0];
         end
         if (wr_hit(`OFS_ANALOG_EN)) begin
            analog_input_enable_reg <= hwdata[15:0];
         end
      end
   end

   // function routing; bus functions outrank peripheral outputs
   always_comb begin
      func_sel = '0;
      func_out = '0;
      func_oe = '0;
      for (int i = 0; i < 4; i++) begin
         if (ext_mode && !upper_address_output_ctrl[i]) begin
            func_sel[`PIN_P2U+i] = 1'b1;
            func_out[`PIN_P2U+i] = bus_func.addr[20+i];
            func_oe[`PIN_P2U+i] = 1'b1;
         end else if (periph_sel[`PSEL_PPG+i]) begin
            func_sel[`PIN_P2U+i] = 1'b1;
            func_out[`PIN_P2U+i] = periph.ppg[i];
            func_oe[`PIN_P2U+i] = 1'b1;
         end
      end
      if (!nmux_bus) begin
         if (periph_sel[`PSEL_TOT]) begin
            func_sel[`PIN_TOT0] = 1'b1;
            func_out[`PIN_TOT0] = periph.tot[0];
            func_oe[`PIN_TOT0] = 1'b1;
         end
         if (periph_sel[`PSEL_TOT+1]) begin
            func_sel[`PIN_TOT1] = 1'b1;
            func_out[`PIN_TOT1] = periph.tot[1];
            func_oe[`PIN_TOT1] = 1'b1;
         end
         if (periph_sel[`PSEL_TOT+2]) begin
            func_sel[`PIN_TOT2] = 1'b1;
            func_out[`PIN_TOT2] = periph.tot[2];
            func_oe[`PIN_TOT2] = 1'b1;
         end
         if (periph_sel[`PSEL_UART]) begin
            func_sel[`PIN_SOT0] = 1'b1;
            func_out[`PIN_SOT0] = periph.sot[0];
            func_oe[`PIN_SOT0] = 1'b1;
            func_sel[`PIN_SCK0] = 1'b1;
            func_out[`PIN_SCK0] = periph.sck[0];
            func_oe[`PIN_SCK0] = periph.sck_oe[0];
         end
         if (periph_sel[`PSEL_UART+1]) begin
            func_sel[`PIN_SOT1] = 1'b1;
            func_out[`PIN_SOT1] = periph.sot[1];
            func_oe[`PIN_SOT1] = 1'b1;
            func_sel[`PIN_SCK1] = 1'b1;
            func_out[`PIN_SCK1] = periph.sck[1];
            func_oe[`PIN_SCK1] = periph.sck_oe[1];
         end
      end
      for (int i = 0; i < 8; i++) begin
         if (nmux_bus) begin
            func_sel[`PIN_P3+i] = 1'b1;
            func_out[`PIN_P3+i] = bus_func.addr[i];
            func_oe[`PIN_P3+i] = 1'b1;
            func_sel[`PIN_P4+i] = 1'b1;
            func_out[`PIN_P4+i] = bus_func.addr[8+i];
            func_oe[`PIN_P4+i] = 1'b1;
         end
      end
      if (ext_mode) begin
         func_sel[`PIN_P5+`P5_ALE] = 1'b1;
         func_out[`PIN_P5+`P5_ALE] = bus_func.ale;
         func_oe[`PIN_P5+`P5_ALE] = 1'b1;
         func_sel[`PIN_P5+`P5_RD] = 1'b1;
         func_out[`PIN_P5+`P5_RD] = bus_func.rd_n;
         func_oe[`PIN_P5+`P5_RD] = 1'b1;
         if (bus_pin_control[`BPC_WR_STROBE]) begin
            func_sel[`PIN_P5+`P5_WR_LO] = 1'b1;
            func_out[`PIN_P5+`P5_WR_LO] = bus_func.wr_lo_n;
            func_oe[`PIN_P5+`P5_WR_LO] = 1'b1;
            if (w16_mode) begin
               func_sel[`PIN_P5+`P5_WR_HI] = 1'b1;
               func_out[`PIN_P5+`P5_WR_HI] = bus_func.wr_hi_n;
               func_oe[`PIN_P5+`P5_WR_HI] = 1'b1;
            end
         end
         if (bus_pin_control[`BPC_HOLD]) begin
            func_sel[`PIN_P5+`P5_HOLD_REQ] = 1'b1;
            func_sel[`PIN_P5+`P5_HOLD_ACK] = 1'b1;
            func_out[`PIN_P5+`P5_HOLD_ACK] = bus_func.hold_ack;
            func_oe[`PIN_P5+`P5_HOLD_ACK] = 1'b1;
         end
         if (bus_pin_control[`BPC_READY]) begin
            func_sel[`PIN_P5+`P5_RDY] = 1'b1;
         end
         if (bus_pin_control[`BPC_CKE]) begin
            func_sel[`PIN_P5+`P5_CLK] = 1'b1;
            func_out[`PIN_P5+`P5_CLK] = bus_func.mclk;
            func_oe[`PIN_P5+`P5_CLK] = 1'b1;
         end
      end
      for (int i = 0; i < 16; i++) begin
         if (analog_input_enable_reg[i]) begin
            func_sel[`PIN_AN+i] = 1'b1;
         end
      end
   end

   pin_output_cell #(.W(`PIN_COUNT)) u_out (
      .core_clk(core_clk),
      .rst(rst),
      .port_data(port_data),
      .port_dir(port_dir),
      .func_sel(func_sel),
      .func_out(func_out),
      .func_oe(func_oe),
      .pin_out(pin_out),
      .pin_oe(pin_oe)
   );

   pin_input_sync #(.W(`PIN_COUNT)) u_sync (
      .core_clk(core_clk),
      .rst(rst),
      .async_in(pin_in),
      .sync_out(pin_sync)
   );

   // standby and analog use cut the digital input path
   always_comb begin
      pin_seen = pin_sync;
      pin_seen[`PIN_AN+:16] = pin_sync[`PIN_AN+:16] & ~analog_input_enable_reg;
      if (standby) begin
         pin_seen = '0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         hold_request <= 1'b0;
         ext_ready <= 1'b1;
      end else begin
         hold_request <= ext_mode && bus_pin_control[`BPC_HOLD] &&
            pin_seen[`PIN_P5+`P5_HOLD_REQ];
         ext_ready <= !(ext_mode && bus_pin_control[`BPC_READY]) ||
            pin_seen[`PIN_P5+`P5_RDY];
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         timer_in <= 3'h0;
         serial_in <= 2'h0;
         analog_connect <= 16'h0000;
      end else begin
         timer_in <= {pin_seen[`PIN_TIN2], pin_seen[`PIN_TIN1], pin_seen[`PIN_TIN0]};
         serial_in <= {pin_seen[`PIN_SIN1], pin_seen[`PIN_SIN0]};
         analog_connect <= analog_input_enable_reg;
      end
   end

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);

   sequence ext_mux_s;
      ext_mode && mux_mode;
   endsequence

   sequence ext_nmux_s;
      ext_mode && !mux_mode;
   endsequence

   sequence data_write_s;
      ext_nmux_s ##0 $changed(port_data[`PIN_P3]);
   endsequence

   upper_gpio_a: assert property (ext_mode && upper_address_output_ctrl[0] &&
      !periph_sel[`PSEL_PPG] |=> pin_oe[`PIN_P2U] == $past(port_dir[`PIN_P2U]) &&
      pin_out[`PIN_P2U] == $past(port_data[`PIN_P2U]))
      else $error("upper pin not a port pin");
   upper_mux_a: assert property ((ext_mux_s ##0 !upper_address_output_ctrl[1]) |=>
      pin_oe[`PIN_P2U+1] && pin_out[`PIN_P2U+1] == $past(bus_func.addr[21]))
      else $error("address bit 21 missing in multiplexed mode");
   upper_nmux_a: assert property ((ext_nmux_s ##0 !upper_address_output_ctrl[3]) |=>
      pin_oe[`PIN_P2U+3] && pin_out[`PIN_P2U+3] == $past(bus_func.addr[23]))
      else $error("address bit 23 missing in non-multiplexed mode");
   low_addr_a: assert property (ext_nmux_s |=> pin_out[`PIN_P3] == $past(bus_func.addr[0]) &&
      pin_out[`PIN_P4+7] == $past(bus_func.addr[15]))
      else $error("low address not on port pins");
   strobe_pins_a: assert property (ext_mode |=> pin_oe[`PIN_P5+`P5_ALE] &&
      pin_out[`PIN_P5+`P5_RD] == $past(bus_func.rd_n))
      else $error("latch enable or read strobe not driven");
   wr_gpio_a: assert property (!bus_pin_control[`BPC_WR_STROBE] |=>
      pin_oe[`PIN_P5+`P5_WR_LO] == $past(port_dir[`PIN_P5+`P5_WR_LO]) &&
      pin_oe[`PIN_P5+`P5_WR_HI] == $past(port_dir[`PIN_P5+`P5_WR_HI]))
      else $error("write strobe pins not port pins");
   wrh_width_a: assert property (ext_mode && bus_pin_control[`BPC_WR_STROBE] && !w16_mode |=>
      pin_out[`PIN_P5+`P5_WR_HI] == $past(port_data[`PIN_P5+`P5_WR_HI]))
      else $error("high strobe driven on 8-bit bus");
   hold_gpio_a: assert property (!bus_pin_control[`BPC_HOLD] |=> !hold_request &&
      pin_oe[`PIN_P5+`P5_HOLD_ACK] == $past(port_dir[`PIN_P5+`P5_HOLD_ACK]))
      else $error("hold pins active while disabled");
   ready_free_a: assert property (!bus_pin_control[`BPC_READY] |=> ext_ready)
      else $error("ready stretches while disabled");
   clk_out_a: assert property (ext_mode && bus_pin_control[`BPC_CKE] |=>
      pin_oe[`PIN_P5+`P5_CLK] && pin_out[`PIN_P5+`P5_CLK] == $past(bus_func.mclk))
      else $error("machine clock not on pin");
   ppg_pin_a: assert property (!ext_mode && periph_sel[`PSEL_PPG+2] |=>
      pin_out[`PIN_P2U+2] == $past(periph.ppg[2]))
      else $error("pulse output missing");
   standby_block_a: assert property (standby |=> timer_in == 3'h0 && !hold_request)
      else $error("input passed in standby");
   analog_pin_a: assert property (analog_input_enable_reg[0] |=>
      !pin_oe[`PIN_AN] && analog_connect[0])
      else $error("analog pin still digital");
   held_level_a: assert property (data_write_s |=>
      pin_out[`PIN_P3] == $past(bus_func.addr[0]))
      else $error("port write reached function pin");
endmodule

/* File: ext_bus_side.sv */
// far-side model of the parallel bus devices facing the pin selector
`timescale 1ns/1ps
module ext_bus_side (
   input wire logic core_clk, // machine clock
   input wire logic [43:0] pin_out, // device pin levels
   input wire logic [43:0] pin_oe, // device drives pin
   input wire logic [43:0] drive, // model drives pin
   input wire logic [43:0] lvl, // level the model drives
   output logic [43:0] pin_in // wire level seen by device
);
   logic [43:0] spin = 44'h00000000000;
   always_ff @(posedge core_clk) begin
      spin <= ~spin;
   end
   // a driven pin reads back through its one buffer
   // loose lines flip every cycle so a stale level never passes
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & drive & lvl) | (~pin_oe & ~drive & spin);
endmodule

/* File: external_bus_pin_function_select_test.sv */
// register-driven tests of the pin function selector
`timescale 1ns/1ps
`include "pin_sel_regs.svh"
module external_bus_pin_function_select_test;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic hsel, hwrite, hreadyout, hresp, hold_request, ext_ready, standby;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0] htrans;
   logic [2:0] hsize;
   pin_sel_pkg::bus_func_t bf;
   pin_sel_pkg::periph_out_t pf;
   logic [43:0] pin_in, pin_out, pin_oe, drive, lvl;
   logic [2:0] timer_in;
   logic [1:0] serial_in;
   logic [15:0] analog_connect;
   int mismatches = 0;
   int total_checks = 0;
   int cycles = 0;
   always #12.5 core_clk = ~core_clk;
   pin_function_select dut (.core_clk(core_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
      .bus_func(bf), .periph(pf), .standby(standby), .pin_in(pin_in),
      .pin_out(pin_out), .pin_oe(pin_oe), .hold_request(hold_request),
      .ext_ready(ext_ready), .timer_in(timer_in), .serial_in(serial_in),
      .analog_connect(analog_connect));
   ext_bus_side far (.core_clk(core_clk), .pin_out(pin_out), .pin_oe(pin_oe),
      .drive(drive), .lvl(lvl), .pin_in(pin_in));
   task end_sim;
      if (mismatches == 0 && total_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task chk(input string n, input logic [31:0] s, input logic [31:0] e);
      total_checks++;
      if (s !== e) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", n, e, s);
      end
   endtask
   task wait_rdy;
      do @(posedge core_clk); while (hreadyout !== 1'b1);
   endtask
   task addr_ph(input logic [7:0] a, input logic w);
      @(posedge core_clk);
      haddr <= {24'h000000, a};
      hwrite <= w;
      htrans <= pin_sel_pkg::HTRANS_NONSEQ;
      wait_rdy();
      htrans <= pin_sel_pkg::HTRANS_IDLE;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      addr_ph(a, 1'b1);
      hwdata <= d;
      wait_rdy();
   endtask
   task rdchk(input string n, input logic [7:0] a, input logic [31:0] e);
      addr_ph(a, 1'b0);
      wait_rdy();
      chk(n, hrdata, e);
   endtask
   // covers the output flop plus the two-flop input path and its output flop
   task settle;
      repeat (5) @(posedge core_clk);
      #1;
   endtask
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 4000) begin
         mismatches++;
         end_sim();
      end
   end
   initial begin
      hsel <= 1'b1;
      haddr <= 32'h00000000;
      htrans <= pin_sel_pkg::HTRANS_IDLE;
      hwrite <= 1'b0;
      hsize <= 3'h2;
      hwdata <= 32'h00000000;
      standby <= 1'b0;
      bf <= {24'hA05AC3, 6'h3F};
      pf <= 13'h0000;
      drive <= 44'h00000000000;
      lvl <= 44'h00000000000;
      repeat (3) @(posedge core_clk);
      rst <= 1'b0;
      // control registers and the unmapped hole above them read zero
      for (int a = 8'h18; a <= 8'h3C; a += 4) begin
         rdchk("reset", a[7:0], 32'h00000000);
      end
      chk("hresp", hresp, 1'h0);
      wr(`OFS_PORT_DIR_LO, 32'hFFFFFFFF);
      wr(`OFS_PORT_DIR_HI, 32'h00000FFF);
      wr(`OFS_BUS_MODE, 32'h00000001);
      settle();
      chk("addr_pins", pin_out[19:0], 20'h5AC3A);
      chk("ale_rd", pin_out[21:20], 2'h3);
      chk("wrl_port", {pin_oe[22], pin_out[22]}, 2'h2);
      wr(`OFS_PORT_DATA_LO, 32'hFFFFFFFF);
      settle();
      chk("func_hold", pin_out[21:0], 22'h35AC3A);
      wr(`OFS_PORT_DATA_LO, 32'h00000000);
      wr(`OFS_UPPER_ADDR, 32'h0000000F);
      settle();
      chk("upper_port", pin_out[3:0], 4'h0);
      wr(`OFS_UPPER_ADDR, 32'h00000000);
      wr(`OFS_BUS_MODE, 32'h00000003);
      settle();
      chk("upper_mux", pin_out[3:0], 4'hA);
      chk("low_port", pin_out[19:4], 16'h0000);
      wr(`OFS_BUS_PIN_CTRL, 32'h00000001);
      settle();
      chk("wr_8bit", pin_out[23:22], 2'h1);
      wr(`OFS_BUS_MODE, 32'h00000007);
      settle();
      chk("wr_16bit", pin_out[23:22], 2'h3);
      drive <= 44'h00005000000;
      lvl <= 44'h00001000000;
      wr(`OFS_BUS_PIN_CTRL, 32'h00000002);
      settle();
      chk("wr_off", pin_out[23:22], 2'h0);
      chk("hold_on", {hold_request, pin_out[25], pin_oe[24]}, 3'h6);
      chk("rdy_off", ext_ready, 1'h1);
      wr(`OFS_BUS_PIN_CTRL, 32'h00000004);
      settle();
      chk("hold_off", {hold_request, pin_out[25]}, 2'h0);
      chk("rdy_on", ext_ready, 1'h0);
      chk("clk_off", pin_out[27], 1'h0);
      wr(`OFS_BUS_PIN_CTRL, 32'h00000008);
      settle();
      chk("clk_on", {pin_out[27], ext_ready}, 2'h3);
      rdchk("bpc_rd", `OFS_BUS_PIN_CTRL, 32'h00000008);
      wr(`OFS_BUS_MODE, 32'h00000000);
      wr(`OFS_PERIPH_SEL, 32'h0000000F);
      pf.ppg <= 4'h6;
      wr(`OFS_PORT_DIR_LO, 32'h00000000);
      drive <= 44'h00000001000;
      lvl <= 44'h00000001000;
      settle();
      chk("ppg_pins", {pin_oe[3:0], pin_out[3:0]}, 8'hF6);
      chk("tin0", timer_in[0], 1'h1);
      wr(`OFS_PERIPH_SEL, 32'h00000090);
      pf.tot <= 3'h1;
      pf.sot <= 2'h1;
      drive <= 44'h00000005000;
      lvl <= 44'h00000005000;
      settle();
      chk("tot_sot", {pin_oe[16:15], pin_out[15], pin_oe[13], pin_out[13]}, 5'h0F);
      chk("sin0", serial_in[0], 1'h1);
      @(posedge core_clk);
      standby <= 1'b1;
      settle();
      chk("standby", {timer_in, serial_in}, 5'h00);
      @(posedge core_clk);
      standby <= 1'b0;
      wr(`OFS_ANALOG_EN, 32'h00008001);
      settle();
      chk("an_conn", analog_connect, 16'h8001);
      chk("an_oe", {pin_oe[43], pin_oe[42], pin_oe[28]}, 3'h2);
      rdchk("an_rd", `OFS_ANALOG_EN, 32'h00008001);
      end_sim();
   end
endmodule
